//--- design/recorder_defines.vh
`ifndef RECORDER_DEFINES_VH
`define RECORDER_DEFINES_VH

// Ring storage geometry
`define REC_WORDS        64
`define REC_ADDR_W       6
`define REC_DATA_W       8

// Bit-clock divider width: top bit is the bit clock, period 2^10 phase-2 pulses
`define REC_DIV_W        10

// Decimal slot counter: ten slots per word, slot 2 loads and strobes
`define REC_SLOTS        10
`define REC_SLOT_RESET   10'h001
`define REC_SLOT_LOAD    2
`define REC_SLOT_ONE     1
`define REC_SLOT_THREE   3

// Byte addresses of the bus registers
`define REC_OFS_CTRL     8'h00
`define REC_OFS_STATUS   8'h04
`define REC_OFS_DATA     8'h08

// Control register fields
`define REC_CTRL_SW_WR   0
`define REC_CTRL_SW_RD   1
`define REC_CTRL_ABORT   2
`define REC_CTRL_PIN_EN  3
`define REC_CTRL_PIN_EN_RST 1'b1

// Status register fields
`define REC_ST_PEND_W    0
`define REC_ST_WACT      1
`define REC_ST_RACT      2
`define REC_ST_PEND_R    3
`define REC_ST_ADDR_LO   8
`define REC_ST_WCNT_LO   16
`define REC_ST_SLOT_LO   24

// Synchronised pin bundle layout
`define REC_PIN_P1       8
`define REC_PIN_P2       9
`define REC_PIN_WR       10
`define REC_PIN_RD       11
`define REC_PIN_RST      12
`define REC_PIN_SER      13
`define REC_PIN_W        14

`endif

//--- design/pin_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the settled stage
module pin_sync #(
  parameter W = 1
) (
  input  wire         hclk,     // System clock
  input  wire         hresetn,  // Asynchronous reset, active low
  input  wire [W-1:0] pin,      // Asynchronous inputs
  output wire [W-1:0] level,    // Synchronised level
  output wire [W-1:0] rise,     // One-cycle pulse on rising edge
  output wire [W-1:0] fall      // One-cycle pulse on falling edge
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] last_q;

  // First stage feeds only the second; edges are taken after the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      last_q <= {W{1'b0}};
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses
  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;

endmodule

//--- design/circular_recorder.v
`timescale 1ns/1ps
`include "recorder_defines.vh"

// Notes on behaviour
// - Write request rising edge sets pending-write until the write cycle starts.
// - Phase-1 rise with pending-write and no read raises write-active, clears pending.
// - While write-active, phase-2 rise stores the 8-bit input word.
// - Storage address advances by one on the phase-2 fall after the strobe.
// - Write-active drops at the next phase-1 rise; writes last one phase-1 period.
// - Memory select is write except while read-active is high.
// - Read request rising edge sets pending-read; read-active follows if no write.
// - Write-active and read-active never overlap; opposite requests wait pending.
// - Read-active rises at the first phase-2 rise after write-active has dropped.
// - Read-active rising releases word counter, bit-clock divider and slot counter.
// - Divider on phase-2 from zero; top bit rises after 2^9, then every 2^10.
// - Slot counter steps on bit-clock fall; each slot high one period of ten.
// - Slot 2 selects load; shift register loads on the mid-slot bit-clock rise.
// - Slot 2 with read-active strobes memory; word shown on parallel outputs.
// - Slot 2 falling advances storage address and read word counter.
// - Loaded MSB appears at once on serial out, then one bit per bit-clock rise.
// - Each word is ten bit periods: eight data then two spacing bits.
// - Spacing bits are the serial input levels captured during later shifts.
// - Bit clock, serial data and slots 1, 2, 3 are brought out as outputs.
// - Storage holds 64 words in a wrapping ring; new words overwrite the oldest.
// - Falling edge of 64th slot-2 pulse clears read-active and pending-read.
// - After read ends, bit clock runs to slot 0, then divider and slots reset.
// - Reset input high aborts a read and clears the word counter, not the address.
module circular_recorder #(
  parameter AW   = `REC_ADDR_W,
  parameter DW   = `REC_DATA_W,
  parameter DIVW = `REC_DIV_W
) (
  input  wire          hclk,          // System clock, 250 MHz
  input  wire          hresetn,       // Asynchronous reset, active low
  input  wire          hsel,          // AHB slave select
  input  wire [31:0]   haddr,         // AHB address
  input  wire [1:0]    htrans,        // AHB transfer type
  input  wire          hwrite,        // AHB write
  input  wire [2:0]    hsize,         // AHB size, word only
  input  wire [31:0]   hwdata,        // AHB write data
  input  wire          hready,        // AHB ready in
  output wire          hreadyout,     // AHB ready out
  output wire          hresp,         // AHB response, always OKAY
  output wire [31:0]   hrdata,        // AHB read data
  input  wire          phase_one,     // Phase-1 clock pin
  input  wire          phase_two,     // Phase-2 clock pin, delayed
  input  wire          write_req,     // Acquisition request pin
  input  wire          read_req,      // Transmission request pin
  input  wire          abort_pin,     // Reset pin, active high
  input  wire          serial_in,     // Spacing code input
  input  wire [DW-1:0] data_in,       // Parallel word from converter
  output wire [DW-1:0] data_out,      // Word presented during slot 2
  output wire          mem_strobe,    // Read strobe, slot 2 with read-active
  output wire          read_select,   // High selects memory read
  output wire          bit_clock,     // Divider top bit
  output wire          serial_out,    // Serial data
  output wire          slot_one,      // Decoded slot 1
  output wire          slot_two,      // Decoded slot 2, load select
  output wire          slot_three     // Decoded slot 3
);

  localparam [DIVW-1:0] DIV_HALF = {1'b0, {(DIVW-1){1'b1}}};
  localparam [DIVW-1:0] DIV_ALL  = {DIVW{1'b1}};
  localparam [AW-1:0]   ADDR_ONE = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW-1:0]   WCNT_END = {AW{1'b1}};

  // Wrapping increment shared by both address advance paths
  function [AW-1:0] ring_next;
    input [AW-1:0] a;
    begin
      ring_next = a + ADDR_ONE;
    end
  endfunction

  // Synchronised pins
  wire [`REC_PIN_W-1:0] pin_lvl;
  wire [`REC_PIN_W-1:0] pin_rise;
  wire [`REC_PIN_W-1:0] pin_fall;

  // Storage and control state
  reg [DW-1:0]   mem_q [0:`REC_WORDS-1];
  reg            pend_w_q;
  reg            wact_q;
  reg            ract_q;
  reg            pend_r_q;
  reg [AW-1:0]   addr_q;
  reg [AW-1:0]   wcnt_q;
  reg [DIVW-1:0] div_q;
  reg [`REC_SLOTS-1:0] slot_q;
  reg [DW-1:0]   shift_q;
  reg [DW-1:0]   data_out_q;
  reg            strobe_q;

  // Bus state
  reg            dph_act_q;
  reg            dph_wr_q;
  reg [7:0]      dph_addr_q;
  reg [31:0]     hrdata_q;
  reg            hreadyout_q;
  reg            hresp_q;
  reg            pin_en_q;
  reg            sw_wr_q;
  reg            sw_rd_q;
  reg            sw_abort_q;

  // Every asynchronous input passes two flops before use
  pin_sync #(
    .W (`REC_PIN_W)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({serial_in, abort_pin, read_req, write_req, phase_two, phase_one, data_in}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  wire          p1_rise  = pin_rise[`REC_PIN_P1];
  wire          p2_rise  = pin_rise[`REC_PIN_P2];
  wire          p2_fall  = pin_fall[`REC_PIN_P2];
  wire [DW-1:0] data_lvl = pin_lvl[DW-1:0];
  wire          ser_lvl  = pin_lvl[`REC_PIN_SER];

  // Request events: pin edges when enabled, or software pulses
  wire wr_evt = (pin_en_q & pin_rise[`REC_PIN_WR]) | sw_wr_q;
  wire rd_evt = (pin_en_q & pin_rise[`REC_PIN_RD]) | sw_rd_q;
  wire abort  = pin_lvl[`REC_PIN_RST] | sw_abort_q;

  // Write starts only while no read is running
  wire w_start = p1_rise & ~wact_q & pend_w_q & ~ract_q;
  // Read starts on phase-2 only once write-active is low
  wire r_start = p2_rise & pend_r_q & ~wact_q & ~ract_q;

  // Divider and slot counter run while reading, then until slot 0 returns
  wire run       = ract_q | ~slot_q[0];
  wire bclk_rise = p2_rise & run & (div_q == DIV_HALF);
  wire bclk_fall = p2_rise & run & (div_q == DIV_ALL);
  wire slot2_end = bclk_fall & slot_q[`REC_SLOT_LOAD] & ract_q;
  wire r_end     = slot2_end & (wcnt_q == WCNT_END);

  // Request and cycle flags
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_w_q <= 1'b0;
      wact_q   <= 1'b0;
      ract_q   <= 1'b0;
      pend_r_q <= 1'b0;
    end else begin
      // A new request in the clearing cycle is kept
      if (wr_evt) begin
        pend_w_q <= 1'b1;
      end else if (w_start) begin
        pend_w_q <= 1'b0;
      end
      // Active from one phase-1 rise to the next, one phase-1 period
      if (p1_rise) begin
        wact_q <= w_start;
      end
      if (abort || r_end) begin
        ract_q <= 1'b0;
      end else if (r_start) begin
        ract_q <= 1'b1;
      end
      if (rd_evt) begin
        pend_r_q <= 1'b1;
      end else if (abort || r_end) begin
        pend_r_q <= 1'b0;
      end
    end
  end

  // Ring storage: phase-2 rise is the write strobe; no reset, contents are data
  always @(posedge hclk) begin
    if (p2_rise && wact_q && !ract_q) begin
      mem_q[addr_q] <= data_lvl;
    end
  end

  // Storage address and read word counter; abort leaves the address alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= {AW{1'b0}};
      wcnt_q <= {AW{1'b0}};
    end else begin
      if (p2_fall && wact_q) begin
        addr_q <= ring_next(addr_q);
      end else if (slot2_end) begin
        addr_q <= ring_next(addr_q);
      end
      if (abort || !ract_q) begin
        wcnt_q <= {AW{1'b0}};
      end else if (slot2_end) begin
        wcnt_q <= ring_next(wcnt_q);
      end
    end
  end

  // Bit-clock divider counts phase-2 pulses from zero while released
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= {DIVW{1'b0}};
    end else if (!run) begin
      div_q <= {DIVW{1'b0}};
    end else if (p2_rise) begin
      div_q <= div_q + {{(DIVW-1){1'b0}}, 1'b1};
    end
  end

  // One-hot slot ring stepped by the inverted bit clock; held at slot 0 when stopped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_q <= `REC_SLOT_RESET;
    end else if (!run) begin
      slot_q <= `REC_SLOT_RESET;
    end else if (bclk_fall) begin
      slot_q <= {slot_q[`REC_SLOTS-2:0], slot_q[`REC_SLOTS-1]};
    end
  end

  // Shift register: load mid-slot-2, otherwise shift in the spacing input
  // Holds its last bit once the clock stops, until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= {DW{1'b0}};
    end else if (bclk_rise) begin
      if (slot_q[`REC_SLOT_LOAD]) begin
        shift_q <= mem_q[addr_q];
      end else begin
        shift_q <= {shift_q[DW-2:0], ser_lvl};
      end
    end
  end

  // Parallel word and strobe for the whole slot-2 pulse of a read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_out_q <= {DW{1'b0}};
      strobe_q   <= 1'b0;
    end else begin
      strobe_q   <= slot_q[`REC_SLOT_LOAD] & ract_q;
      data_out_q <= (slot_q[`REC_SLOT_LOAD] && ract_q) ? mem_q[addr_q] : {DW{1'b0}};
    end
  end

  // Bus address phase captured when the slave is selected and the bus is ready
  wire addr_ok = hsel & htrans[1] & hready;

  // Status snapshot for reads
  wire [31:0] status_w = {5'h00, slot_q[`REC_SLOT_THREE], slot_q[`REC_SLOT_LOAD],
                          slot_q[`REC_SLOT_ONE],
                          {(8-AW){1'b0}}, wcnt_q,
                          {(8-AW){1'b0}}, addr_q,
                          4'h0, pend_r_q, ract_q, wact_q, pend_w_q};

  // AHB-Lite slave: zero wait states, read data registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_act_q   <= 1'b0;
      dph_wr_q    <= 1'b0;
      dph_addr_q  <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      pin_en_q    <= `REC_CTRL_PIN_EN_RST;
      sw_wr_q     <= 1'b0;
      sw_rd_q     <= 1'b0;
      sw_abort_q  <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      sw_wr_q     <= 1'b0;
      sw_rd_q     <= 1'b0;
      sw_abort_q  <= 1'b0;
      dph_act_q   <= addr_ok;
      if (addr_ok) begin
        dph_wr_q   <= hwrite;
        dph_addr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
      end
      // Unmapped addresses read zero
      if (addr_ok && !hwrite) begin
        if (haddr[31:8] != 24'h00_0000) begin
          hrdata_q <= 32'h0000_0000;
        end else begin
          case (haddr[7:0])
            `REC_OFS_CTRL:   hrdata_q <= {28'h000_0000, pin_en_q, 3'h0};
            `REC_OFS_STATUS: hrdata_q <= status_w;
            `REC_OFS_DATA:   hrdata_q <= {24'h00_0000, shift_q};
            default:         hrdata_q <= 32'h0000_0000;
          endcase
        end
      end
      // Write data phase; command bits act as one-cycle pulses
      if (dph_act_q && dph_wr_q && dph_addr_q == `REC_OFS_CTRL) begin
        pin_en_q   <= hwdata[`REC_CTRL_PIN_EN];
        sw_wr_q    <= hwdata[`REC_CTRL_SW_WR];
        sw_rd_q    <= hwdata[`REC_CTRL_SW_RD];
        sw_abort_q <= hwdata[`REC_CTRL_ABORT];
      end
    end
  end

  // Outputs, each straight from a flop
  assign hreadyout   = hreadyout_q;
  assign hresp       = hresp_q;
  assign hrdata      = hrdata_q;
  assign data_out    = data_out_q;
  assign mem_strobe  = strobe_q;
  assign read_select = ract_q;
  assign bit_clock   = div_q[DIVW-1];
  assign serial_out  = shift_q[DW-1];
  assign slot_one    = slot_q[`REC_SLOT_ONE];
  assign slot_two    = slot_q[`REC_SLOT_LOAD];
  assign slot_three  = slot_q[`REC_SLOT_THREE];

endmodule

//--- dv/rec_checker_assertions.sv
`timescale 1ns/1ps
// Pin-level checks for the recorder's bus response and read-out path timing
module rec_checker #(
  parameter DIVW = 10
) (
  input wire logic       hclk,        // Bus clock
  input wire logic       hresetn,     // Reset, active low
  input wire logic       hreadyout,   // Ready out
  input wire logic       hresp,       // Response
  input wire logic       phase_two,   // Phase-2 pin
  input wire logic       abort_pin,   // Abort pin
  input wire logic [7:0] data_out,    // Strobed word
  input wire logic       mem_strobe,  // Read strobe
  input wire logic       read_select, // Read mode
  input wire logic       bit_clock,   // Bit clock
  input wire logic       serial_out,  // Serial data
  input wire logic       slot_one,    // Slot 1
  input wire logic       slot_two,    // Slot 2
  input wire logic       slot_three   // Slot 3
);
  localparam int HALF = 1 << (DIVW - 1);
  logic        p2_q;
  logic [15:0] p2_cnt;
  logic [7:0]  strobe_cnt;
  logic        abort_seen;
  // Phase-2 pulses per bit-clock half, strobes per read; abort excuses a short read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p2_q       <= 1'b0;
      p2_cnt     <= 16'h0000;
      strobe_cnt <= 8'h00;
      abort_seen <= 1'b0;
    end else begin
      p2_q <= phase_two;
      if ($changed(bit_clock)) p2_cnt <= 16'h0000;
      else if (phase_two && !p2_q) p2_cnt <= p2_cnt + 16'h0001;
      if ($rose(read_select)) strobe_cnt <= 8'h00;
      else if ($rose(mem_strobe)) strobe_cnt <= strobe_cnt + 8'h01;
      if ($rose(read_select)) abort_seen <= 1'b0;
      else if (abort_pin) abort_seen <= 1'b1;
    end
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_strobe_in_slot: assert property (mem_strobe |-> $past(slot_two)) else $error("strobe outside slot 2");
  a_data_idle: assert property (!mem_strobe |-> data_out == 8'h00) else $error("data out without strobe");
  a_slots_onehot: assert property ($onehot0({slot_one, slot_two, slot_three})) else $error("slots overlap");
  a_slot_order: assert property ($rose(slot_three) |-> $fell(slot_two)) else $error("slot 3 not after 2");
  a_slot_on_fall: assert property ($rose(slot_one) |-> !bit_clock) else $error("slot step on high bit clock");
  a_load_msb: assert property ($rose(bit_clock) && slot_two && mem_strobe |-> ##[1:3] serial_out == data_out[7])
    else $error("loaded msb not on serial out");
  a_serial_moves: assert property ($changed(serial_out) |-> bit_clock) else $error("serial changed off rise");
  a_bit_half: assert property (disable iff (!hresetn || abort_pin) $fell(bit_clock) |-> p2_cnt == HALF)
    else $error("bit clock half period wrong");
  a_read_words: assert property ($fell(read_select) |-> strobe_cnt == 8'd64 || abort_seen)
    else $error("read did not end after 64 words");
endmodule

bind circular_recorder rec_checker #(.DIVW(DIVW)) u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .phase_two(phase_two), .abort_pin(abort_pin), .data_out(data_out), .mem_strobe(mem_strobe),
  .read_select(read_select), .bit_clock(bit_clock), .serial_out(serial_out), .slot_one(slot_one),
  .slot_two(slot_two), .slot_three(slot_three));

//--- dv/rec_far_side.sv
`timescale 1ns/1ps
// Converter, request timers and tone link as seen from the recorder pins
module rec_far_side (
  input  wire logic       hclk,       // Bench clock
  input  wire logic       fire_wr,    // Start an acquisition request
  input  wire logic       fire_rd,    // Start a transmission request
  input  wire logic       slot_three, // Decoded slot 3 from the recorder
  output logic            phase_one,  // Phase-1 clock
  output logic            phase_two,  // Phase-2 clock
  output wire logic       write_req,  // Acquisition request pin
  output wire logic       read_req,   // Transmission request pin
  output wire logic       serial_in,  // Spacing code
  output logic      [7:0] data_in     // Converter word
);
  int ph = 0;
  int n = 0;
  int wr_t = 0;
  int rd_t = 0;
  // Quiet pins at time zero
  initial begin
    phase_one = 1'b0;
    phase_two = 1'b0;
    data_in = 8'h00;
  end
  // Free-running two-phase source; phase two rises later and is narrow
  always @(posedge hclk) begin
    ph <= (ph + 1) % 16;
    phase_one <= ph < 8;
    phase_two <= ph >= 2 && ph < 6;
  end
  // Requests are long enough to pass the pin synchronisers; the word changes with the request edge
  always @(posedge hclk) begin
    if (fire_wr) begin
      data_in <= 8'(n * 37 + 5);
      n <= n + 1;
    end
    wr_t <= fire_wr ? 8 : (wr_t > 0 ? wr_t - 1 : 0);
    rd_t <= fire_rd ? 8 : (rd_t > 0 ? rd_t - 1 : 0);
  end
  assign write_req = wr_t > 0;
  assign read_req  = rd_t > 0;
  // Slot 3 wired back gives spacing bits one then zero
  assign serial_in = slot_three;
endmodule

//--- dv/test_circular_recorder.sv
`timescale 1ns/1ps
module test_circular_recorder;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        abort_pin = 1'b0;
  logic        fire_wr = 1'b0;
  logic        fire_rd = 1'b0;
  wire         hreadyout, hresp, phase_one, phase_two, write_req, read_req, serial_in;
  wire         mem_strobe, read_select, bit_clock, serial_out, slot_one, slot_two, slot_three;
  wire [31:0]  hrdata;
  wire [7:0]   data_in, data_out;
  int          mismatches = 0;
  int          check_count = 0;
  logic [31:0] st;

  always #2 hclk = ~hclk;

  // Short divider keeps a full read-out near 41k cycles
  circular_recorder #(.DIVW(2)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .phase_one(phase_one), .phase_two(phase_two), .write_req(write_req),
    .read_req(read_req), .abort_pin(abort_pin), .serial_in(serial_in), .data_in(data_in), .data_out(data_out),
    .mem_strobe(mem_strobe), .read_select(read_select), .bit_clock(bit_clock), .serial_out(serial_out),
    .slot_one(slot_one), .slot_two(slot_two), .slot_three(slot_three));
  rec_far_side u_far (.hclk(hclk), .fire_wr(fire_wr), .fire_rd(fire_rd), .slot_three(slot_three),
    .phase_one(phase_one), .phase_two(phase_two), .write_req(write_req), .read_req(read_req),
    .serial_in(serial_in), .data_in(data_in));

  function automatic logic [7:0] word_of(input int n);
    return 8'(n * 37 + 5);
  endfunction

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer; each phase is held until ready is sampled high at a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      mismatches++;
      $display("MISMATCH bus ready expected 1 seen 0");
      close_out();
    end
  endtask

  task automatic pulse(input int which);
    if (which == 0) fire_wr <= 1'b1;
    else fire_rd <= 1'b1;
    @(posedge hclk);
    fire_wr <= 1'b0;
    fire_rd <= 1'b0;
  endtask

  // Waits for a bit-clock rise (0), read start (1) or read end (2), bounded
  task automatic wait_for(input int sel, input int lim);
    int n;
    logic prev;
    n = 0;
    prev = 1'b1;
    forever begin
      @(negedge hclk);
      if (sel == 0 ? (bit_clock === 1'b1 && !prev) : (read_select === (sel == 1))) break;
      prev = bit_clock;
      n++;
      if (n > lim) begin
        mismatches++;
        $display("MISMATCH wait %0d expected event seen none", sel);
        close_out();
      end
    end
    @(posedge hclk);
  endtask

  task automatic check_regs();
    ahb(1'b0, 32'h0, 32'h0, st);
    chk("ctrl reset", 32'h8, st);
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("status reset", 32'h0, st);
    ahb(1'b1, 32'h40, 32'hffff_ffff, st);
    ahb(1'b0, 32'h40, 32'h0, st);
    chk("unmapped read", 32'h0, st);
    ahb(1'b1, 32'h0, 32'h0, st);
    ahb(1'b0, 32'h0, 32'h0, st);
    chk("ctrl enable cleared", 32'h0, st);
    ahb(1'b1, 32'h0, 32'h8, st);
  endtask

  // Seventy writes wrap the ring; the address lands on the oldest word
  task automatic fill_ring();
    for (int i = 0; i < 70; i++) begin
      pulse(0);
      repeat (48) @(posedge hclk);
    end
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("address after wrap", 32'h6, st[13:8]);
    chk("flags after writes", 32'h0, st[3:0]);
  endtask

  // Full read-out, oldest first, with a write request parked in the middle
  task automatic stream_out();
    int i;
    int ran;
    logic [7:0] w;
    logic b;
    pulse(1);
    i = 0;
    do begin wait_for(0, 400); i++; end while (slot_two !== 1'b1 && i < 20);
    for (int k = 0; k < 638; k++) begin
      if (k > 0) wait_for(0, 200);
      repeat (3) @(posedge hclk);
      w = word_of(k / 10 + 6);
      b = (k % 10 < 8) ? w[7 - k % 10] : (k % 10 == 8);
      chk("serial bit", {31'h0, b}, {31'h0, serial_out});
      if (k == 300) begin
        pulse(0);
        repeat (20) @(posedge hclk);
        ahb(1'b0, 32'h4, 32'h0, st);
        chk("write held in read", 32'hd, st[3:0]);
      end
    end
    repeat (40) @(posedge hclk);
    ran = 0;
    repeat (300) begin @(negedge hclk); if (bit_clock !== 1'b0) ran = 1; end
    @(posedge hclk);
    chk("bit clock stopped", 32'h0, ran);
    w = word_of(69);
    chk("serial holds last", {31'h0, w[0]}, {31'h0, serial_out});
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("address after read", 32'h7, st[13:8]);
    chk("flags after read", 32'h0, st[3:0]);
  endtask

  // Read requested during a write waits for it; then an abort mid-read
  task automatic priority_abort();
    int i;
    pulse(0);
    i = 0;
    // The read request must land while the write is really running, not merely pending
    do begin ahb(1'b0, 32'h4, 32'h0, st); i++; end while (st[1] !== 1'b1 && i < 20);
    chk("write active before read", 32'h1, st[1]);
    pulse(1);
    wait_for(1, 400);
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("address at read start", 32'h8, st[13:8]);
    chk("flags at read start", 32'hc, st[3:0]);
    repeat (25) wait_for(0, 200);
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("word count mid read", 32'h3, st[21:16]);
    chk("address mid read", 32'hb, st[13:8]);
    abort_pin <= 1'b1;
    repeat (40) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0, st);
    abort_pin <= 1'b0;
    chk("flags after abort", 32'h0, st[3:0]);
    chk("count after abort", 32'h0, st[21:16]);
    chk("address after abort", 32'hb, st[13:8]);
    chk("read mode after abort", 32'h0, {31'h0, read_select});
  endtask

  // Software request bits in the control word, pins left enabled
  task automatic sw_requests();
    repeat (500) @(posedge hclk);
    ahb(1'b1, 32'h0, 32'h9, st);
    repeat (40) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("address after software write", 32'hc, st[13:8]);
    chk("flags after software write", 32'h0, st[3:0]);
    ahb(1'b1, 32'h0, 32'ha, st);
    wait_for(1, 400);
    abort_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    abort_pin <= 1'b0;
    repeat (5) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0, st);
    chk("flags after software read", 32'h0, st[3:0]);
  endtask

  // Watchdog against a hang anywhere in the sequence
  initial begin
    #400000;
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    close_out();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_regs();
    fill_ring();
    stream_out();
    priority_abort();
    sw_requests();
    close_out();
  end
endmodule
